// ---- apo_consts.svh ----
// constants of the converter output port: offsets, fields, resets, timing
`ifndef APO_CONSTS_SVH
`define APO_CONSTS_SVH
`define APO_WORD_W 14
`define APO_ADDR_W 12
`define APO_CTRL_OFS 12'h000
`define APO_STATUS_OFS 12'h004
`define APO_INT_STAT_OFS 12'h008
`define APO_INT_MASK_OFS 12'h00C
`define APO_LAST_WORD_OFS 12'h010
`define APO_CTRL_HIZ_BIT 0
`define APO_CTRL_STALL_EN_BIT 1
`define APO_CTRL_RST 2'h2
`define APO_INT_W 3
`define APO_INT_WORD_BIT 0
`define APO_INT_RANGE_BIT 1
`define APO_INT_STALL_BIT 2
`define APO_INT_MASK_RST 3'h0
`define APO_CLK_NS 10
`define APO_MIN_RATE_PERIOD_NS 1000
`define APO_STALL_CYC ((`APO_MIN_RATE_PERIOD_NS + `APO_CLK_NS - 1) / `APO_CLK_NS)
`define APO_CNT_W 8
`endif

// ---- apo_pkg.sv ----
// types of the converter output port
package apo_pkg;
  // one conversion result with its range flag
  typedef struct packed {
    logic range;
    logic [13:0] word;
  } apo_result_t;
  // sample clock supervision, gray coded
  typedef enum logic [1:0] {
    APO_IDLE = 2'h0,
    APO_RUN = 2'h1,
    APO_STALL = 2'h3
  } apo_link_t;
endpackage : apo_pkg

// ---- apo_port.sv ----
// parallel result output port with forwarded clock and apb status block
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "apo_consts.svh"
module apo_port (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic sample_clock_in, // sample clock pin
  input wire logic output_enable_n, // output enable pin, low floats
  input wire logic number_format_select, // format pin
  input wire logic [13:0] core_result, // converter core word, offset binary
  input wire logic core_range, // converter core range flag
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [13:0] result_out, // parallel result word
  output logic result_oe, // result word drive enable
  output logic range_exceeded_flag, // range flag pin
  output logic range_oe, // range flag drive enable
  output logic forwarded_sample_clock, // clock pin
  output logic fwd_clk_oe, // clock drive enable
  output logic irq // level interrupt
);
  // offset binary from core, two's complement by flipping the msb
  function automatic logic [13:0] apo_fmt(input logic [13:0] w, input logic ob);
    apo_fmt = ob ? w : {~w[13], w[12:0]};
  endfunction : apo_fmt

  logic [1:0] enc_sync_reg;
  logic [1:0] oe_sync_reg;
  logic [1:0] fmt_sync_reg;
  logic enc_prev_reg;
  logic [1:0] dly_reg;
  logic clk_fwd_reg;
  logic fwd_prev_reg;
  apo_pkg::apo_result_t pend_reg;
  apo_pkg::apo_result_t res_out_reg;
  logic oe_reg;
  apo_pkg::apo_link_t link_reg;
  logic [`APO_CNT_W-1:0] idle_cnt_reg;
  logic [1:0] ctrl_reg;
  logic [`APO_INT_W-1:0] int_stat_reg;
  logic [`APO_INT_W-1:0] int_mask_reg;
  logic [`APO_INT_W-1:0] int_stat_next;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  logic rd_hit;
  logic pready_reg;
  logic pslverr_reg;
  logic enc_rise;
  logic upd_w;
  logic stall_ev;
  logic acc_w;
  logic wr_fire;
  logic [`APO_INT_W-1:0] ev_w;
  logic [`APO_INT_W-1:0] clr_w;

  // pins cross in through two flops; only the second stage is read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      enc_sync_reg <= 2'h0;
      oe_sync_reg <= 2'h0;
      fmt_sync_reg <= 2'h0;
    end else if (clk_en) begin
      enc_sync_reg <= {enc_sync_reg[0], sample_clock_in};
      oe_sync_reg <= {oe_sync_reg[0], output_enable_n};
      fmt_sync_reg <= {fmt_sync_reg[0], number_format_select};
    end
  end

  // sample edge found at 10ns resolution; phases under a cycle can be missed
  // relies on wide phases
  assign enc_rise = enc_sync_reg[1] & ~enc_prev_reg & clk_en;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      enc_prev_reg <= 1'h0;
      dly_reg <= 2'h0;
      clk_fwd_reg <= 1'h0;
      fwd_prev_reg <= 1'h0;
    end else if (clk_en) begin
      enc_prev_reg <= enc_sync_reg[1];
      dly_reg <= {dly_reg[0], enc_sync_reg[1]};
      clk_fwd_reg <= dly_reg[1];
      fwd_prev_reg <= clk_fwd_reg;
    end
  end

  // falling edge of the forwarded clock launches the next word
  assign upd_w = fwd_prev_reg & ~clk_fwd_reg & clk_en;

  // result held at the sample edge until the forwarded clock falls
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_reg <= '0;
    end else if (enc_rise) begin
      pend_reg.word <= core_result;
      pend_reg.range <= core_range;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      res_out_reg <= '0;
    end else if (upd_w) begin
      res_out_reg.word <= apo_fmt(pend_reg.word, fmt_sync_reg[1]);
      res_out_reg.range <= pend_reg.range;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      oe_reg <= 1'h0;
    end else if (clk_en) begin
      oe_reg <= oe_sync_reg[1] & ~ctrl_reg[`APO_CTRL_HIZ_BIT];
    end
  end

  assign stall_ev = (link_reg == apo_pkg::APO_RUN) & ~enc_rise & clk_en
    & ctrl_reg[`APO_CTRL_STALL_EN_BIT]
    & (idle_cnt_reg == `APO_CNT_W'(`APO_STALL_CYC - 1));

  // link supervision; a stalled clock is reported, data simply stops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      link_reg <= apo_pkg::APO_IDLE;
      idle_cnt_reg <= '0;
    end else if (clk_en) begin
      if (enc_rise) begin
        link_reg <= apo_pkg::APO_RUN;
        idle_cnt_reg <= '0;
      end else if (stall_ev) begin
        link_reg <= apo_pkg::APO_STALL;
        idle_cnt_reg <= '0;
      end else if (link_reg == apo_pkg::APO_RUN) begin
        idle_cnt_reg <= idle_cnt_reg + `APO_CNT_W'(1);
      end
    end
  end

  // apb: one wait state, write lands when pready is seen
  assign acc_w = psel & penable & ~pready_reg;
  assign wr_fire = psel & penable & pready_reg & pwrite & clk_en;

  // read mux with unmapped detection
  always_comb begin
    rd_next = 32'h0;
    rd_hit = 1'b1;
    unique case (paddr)
      `APO_CTRL_OFS: rd_next[1:0] = ctrl_reg;
      `APO_STATUS_OFS: rd_next[4:0] = {res_out_reg.range, link_reg, oe_reg, fmt_sync_reg[1]};
      `APO_INT_STAT_OFS: rd_next[`APO_INT_W-1:0] = int_stat_reg;
      `APO_INT_MASK_OFS: rd_next[`APO_INT_W-1:0] = int_mask_reg;
      `APO_LAST_WORD_OFS: rd_next[13:0] = res_out_reg.word;
      default: rd_hit = 1'b0;
    endcase
  end

  // bus answer flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
      prdata_reg <= 32'h0;
    end else if (clk_en) begin
      pready_reg <= acc_w;
      pslverr_reg <= acc_w & ~rd_hit;
      prdata_reg <= (acc_w & ~pwrite) ? rd_next : 32'h0;
    end
  end

  // software control registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `APO_CTRL_RST;
      int_mask_reg <= `APO_INT_MASK_RST;
    end else if (wr_fire) begin
      if (paddr == `APO_CTRL_OFS) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (paddr == `APO_INT_MASK_OFS) begin
        int_mask_reg <= pwdata[`APO_INT_W-1:0];
      end
    end
  end

  // sticky events, write one to clear, a new event beats the clear
  assign ev_w = {stall_ev, upd_w & pend_reg.range, upd_w};
  assign clr_w = (wr_fire && paddr == `APO_INT_STAT_OFS) ? pwdata[`APO_INT_W-1:0] : '0;
  assign int_stat_next = (int_stat_reg & ~clr_w) | ev_w;

  // status and interrupt line
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      int_stat_reg <= '0;
      irq_reg <= 1'h0;
    end else if (clk_en) begin
      int_stat_reg <= int_stat_next;
      irq_reg <= |(int_stat_next & int_mask_reg);
    end
  end

  // every pin straight from a flop
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign result_out = res_out_reg.word;
  assign range_exceeded_flag = res_out_reg.range;
  assign forwarded_sample_clock = clk_fwd_reg;
  assign result_oe = oe_reg;
  assign range_oe = oe_reg;
  assign fwd_clk_oe = oe_reg;
  assign irq = irq_reg;

  // checks
  fmt_select_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    upd_w |=> res_out_reg.word == ($past(fmt_sync_reg[1]) ? $past(pend_reg.word)
      : ($past(pend_reg.word) ^ 14'h2000)))
    else $error("result word format wrong");
  range_copy_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    upd_w |=> range_exceeded_flag == $past(pend_reg.range))
    else $error("range flag not carried");
  clk_delay_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(enc_sync_reg[1]) && clk_en ##1 clk_en [*2] |=> $rose(forwarded_sample_clock))
    else $error("forwarded clock delay wrong");
  upd_fall_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(result_out) |-> $past(fwd_prev_reg) && !$past(clk_fwd_reg))
    else $error("word changed without clock fall");
  steady_rise_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(forwarded_sample_clock) |-> $stable(result_out) ##1 $stable(result_out))
    else $error("word moved at rising edge");
  hiz_all_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !oe_sync_reg[1] && clk_en |=> !result_oe && !range_oe && !fwd_clk_oe)
    else $error("pins driven while disabled");
  same_edge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(range_exceeded_flag) |-> $past(upd_w))
    else $error("flag moved apart from word");
  stall_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    stall_ev |=> link_reg == apo_pkg::APO_STALL && int_stat_reg[`APO_INT_STALL_BIT])
    else $error("stall not reported");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ev_w[0] && clr_w[0] |=> int_stat_reg[0])
    else $error("event lost to clear");
  apb_wait_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    acc_w && clk_en |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  // bus answer shape: data and error only in the ready cycle
  apb_rdata_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  apb_err_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    pslverr |-> pready)
    else $error("error without ready");
  // interrupt line follows masked status once the mask has settled
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $stable(int_mask_reg) |-> irq == (|(int_stat_reg & int_mask_reg)))
    else $error("interrupt line wrong");
  // pin enables under software and pin control
  hiz_ctrl_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_reg[`APO_CTRL_HIZ_BIT] && clk_en |=> !result_oe && !range_oe && !fwd_clk_oe)
    else $error("pins driven while forced off");
  oe_on_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    oe_sync_reg[1] && !ctrl_reg[`APO_CTRL_HIZ_BIT] && clk_en |=> result_oe && fwd_clk_oe)
    else $error("pins not driven while enabled");
  // sample edge takes word and flag as one pair
  sample_take_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    enc_rise |=> pend_reg.word == $past(core_result) && pend_reg.range == $past(core_range))
    else $error("sample not taken");
  // falling edge goes through the same chain, so duty is kept
  fwd_fall_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(enc_sync_reg[1]) && clk_en ##1 clk_en [*2] |=> $fell(forwarded_sample_clock))
    else $error("forwarded clock fall delay wrong");
  // a live sample clock keeps the link running
  run_state_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    enc_rise |=> link_reg == apo_pkg::APO_RUN)
    else $error("link not running after edge");
  // scenarios worth seeing
  clr_cov: cover property (@(posedge clk_sys) disable iff (!nrst) ev_w[0] && clr_w[0]);
  twos_cov: cover property (@(posedge clk_sys) disable iff (!nrst) upd_w && !fmt_sync_reg[1]);
  range_cov: cover property (@(posedge clk_sys) disable iff (!nrst) upd_w && pend_reg.range);
  stall_cov: cover property (@(posedge clk_sys) disable iff (!nrst) stall_ev);
  hiz_cov: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(result_oe));
endmodule : apo_port

// ---- apo_capture.sv ----
// capturing logic model: latches the port's pins on the forwarded clock
module apo_capture (
  input wire logic forwarded_sample_clock, // clock pin from the port
  input wire logic [13:0] result_out, // result word pin
  input wire logic range_exceeded_flag, // range flag pin
  input wire logic result_oe, // word drive enable
  output apo_pkg::apo_result_t captured // last latched word and flag
);
  // latch on forwarded rise
  // a floating bus carries nothing, so it is not taken
  always_ff @(posedge forwarded_sample_clock) begin
    if (result_oe) begin
      captured <= {range_exceeded_flag, result_out};
    end
  end
endmodule : apo_capture

// ---- adc_parallel_output_port_tb.sv ----
// bench of the converter output port: capture, format, range, hi-z, apb, interrupt
`include "apo_consts.svh"
module adc_parallel_output_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic sample_clock_in = 1'b0;
  logic sclk_run = 1'b0;
  logic clk_en = 1'b1;
  logic output_enable_n = 1'b1;
  logic number_format_select = 1'b1;
  logic [13:0] core_result = 14'h0000;
  logic core_range = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [13:0] result_out;
  logic [13:0] prev_out;
  logic result_oe;
  logic range_exceeded_flag;
  logic range_oe;
  logic forwarded_sample_clock;
  logic fwd_clk_oe;
  logic irq;
  apo_pkg::apo_result_t cap;
  logic [15:0] seed = 16'hE908;
  logic [14:0] last_exp;
  logic [31:0] tmp;
  logic terr;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_in = 0;
  int n_fwd = 0;

  always #5 clk_sys = ~clk_sys;

  // 80ns phases, well above the minimum rate
  always begin
    #80;
    sample_clock_in = sclk_run ? ~sample_clock_in : 1'b0;
  end

  apo_port i_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .sample_clock_in(sample_clock_in), .output_enable_n(output_enable_n),
    .number_format_select(number_format_select), .core_result(core_result),
    .core_range(core_range), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result_out(result_out), .result_oe(result_oe),
    .range_exceeded_flag(range_exceeded_flag), .range_oe(range_oe),
    .forwarded_sample_clock(forwarded_sample_clock), .fwd_clk_oe(fwd_clk_oe), .irq(irq));

  apo_capture i_cap (.forwarded_sample_clock(forwarded_sample_clock),
    .result_out(result_out), .range_exceeded_flag(range_exceeded_flag),
    .result_oe(result_oe), .captured(cap));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // core delivers offset binary; two's complement flips the top bit
  function automatic logic [14:0] exp_pin(input logic fmt, input logic rng,
      input logic [13:0] w);
    return {rng, fmt ? w : {~w[13], w[12:0]}};
  endfunction : exp_pin

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // master holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h00000000, v, e);
    chk(v, exp);
    chk({31'h0, e}, {31'h0, eexp});
  endtask : rd_chk

  // word held for four sample periods, then the captured pins compared
  task automatic send(input logic fmt, input logic rng, input logic [13:0] w);
    @(posedge clk_sys);
    core_result <= w;
    core_range <= rng;
    number_format_select <= fmt;
    sclk_run <= 1'b1;
    last_exp = exp_pin(fmt, rng, w);
    repeat (64) @(posedge clk_sys);
    chk({17'h0, cap}, {17'h0, last_exp});
  endtask : send

  // edge counts and data movement watched all run long
  always @(posedge sample_clock_in) n_in++;
  always @(posedge forwarded_sample_clock) n_fwd++;
  always @(posedge clk_sys) begin
    if (result_out !== prev_out) chk({31'h0, forwarded_sample_clock}, 32'h0);
    prev_out <= result_out;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk(`APO_CTRL_OFS, {30'h0, `APO_CTRL_RST}, 1'b0);
    rd_chk(`APO_INT_MASK_OFS, 32'h00000000, 1'b0);
    rd_chk(12'h020, 32'h00000000, 1'b1);
    $display("test registers done");
    // corner words first, random ones after
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      send(i[0], i[1], i < 2 ? {14{i[0]}} : seed[13:0]);
    end
    rd_chk(`APO_LAST_WORD_OFS, {18'h0, last_exp[13:0]}, 1'b0);
    // clear of bit0 timed onto a launch cycle: phases are 8 clocks, set must win
    @(posedge forwarded_sample_clock);
    repeat (5) @(posedge clk_sys);
    apb(1'b1, `APO_INT_STAT_OFS, 32'h00000001, tmp, terr);
    rd_chk(`APO_INT_STAT_OFS, 32'h00000003, 1'b0);
    $display("test capture done");
    sclk_run <= 1'b0;
    repeat (150) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`APO_INT_STAT_OFS, 32'h00000007, 1'b0);
    // range flag set, link stalled, pins on, offset binary
    rd_chk(`APO_STATUS_OFS, 32'h0000001F, 1'b0);
    apb(1'b1, `APO_INT_MASK_OFS, 32'h00000004, tmp, terr);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `APO_INT_STAT_OFS, 32'h00000007, tmp, terr);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    // enable moved only while idle; a low clock enable holds the pins first
    clk_en <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk({29'h0, result_oe, range_oe, fwd_clk_oe}, 32'h7);
    clk_en <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk({29'h0, result_oe, range_oe, fwd_clk_oe}, 32'h0);
    output_enable_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk({29'h0, result_oe, range_oe, fwd_clk_oe}, 32'h7);
    // software force of the floating state, then back to the reset control
    apb(1'b1, `APO_CTRL_OFS, 32'h00000001, tmp, terr);
    repeat (4) @(posedge clk_sys);
    chk({29'h0, result_oe, range_oe, fwd_clk_oe}, 32'h0);
    rd_chk(`APO_CTRL_OFS, 32'h00000001, 1'b0);
    apb(1'b1, `APO_CTRL_OFS, {30'h0, `APO_CTRL_RST}, tmp, terr);
    repeat (4) @(posedge clk_sys);
    chk({29'h0, result_oe, range_oe, fwd_clk_oe}, 32'h7);
    chk(n_fwd, n_in);
    $display("test hi-z and clock done");
    wrap_up();
  end
endmodule : adc_parallel_output_port_tb
